/* logic/wsts_cfg.svh */
// Offsets, field positions, reset values and timing figures of the sequencer.
`ifndef WSTS_CFG_SVH
`define WSTS_CFG_SVH
`define WSTS_REG_STATUS        16'h0017
`define WSTS_REG_COMMAND       16'h0018
`define WSTS_REG_TRIG_ENABLE   16'h0019
`define WSTS_REG_MEM_INDEX     16'h001A
`define WSTS_REG_MEM_DATA      16'h001B
`define WSTS_REG_CLAMP_RISE    16'h0066
`define WSTS_REG_CLAMP_FALL    16'h0067
`define WSTS_REG_LEVEL_RISE    16'h006E
`define WSTS_REG_LEVEL_FALL    16'h006F
`define WSTS_REG_LOG_START     16'h0078
`define WSTS_IDX_W             9
`define WSTS_IDX_RESET         9'h1FF
`define WSTS_IDX_ABORT         9'h1FF
`define WSTS_IDX_LAST          9'h1FB
`define WSTS_IDX_BOOT          9'h180
`define WSTS_MEM_DEPTH         508
`define WSTS_BUSY_BIT          9
`define WSTS_CMD_RESTORE_BIT   0
`define WSTS_CMD_BOOT_BIT      1
`define WSTS_EN_LEVEL_BIT      0
`define WSTS_EN_CLAMP_RISE_BIT 1
`define WSTS_EN_CLAMP_FALL_BIT 2
`define WSTS_DELAY_END         4'hF
`define WSTS_DELAY_NONE        4'h0
`define WSTS_EXT_BASE_OP       8'h11
`define WSTS_EXT_JUMP_OP       16'h12FF
`define WSTS_CLK_MHZ           250
`define WSTS_SHORT_STEP_NS     3300
`define WSTS_UNIT_STEP_NS      61440
`define WSTS_TRIM_ADDR         12'h000
`define WSTS_TRIM_WIDTH        3'h7
`endif

/* logic/wsts_pkg.sv */
// Types shared by the write sequencer trigger and status logic.
package wsts_pkg;
  typedef enum logic [2:0] {
    WSTS_IDLE    = 3'h0,
    WSTS_FETCH   = 3'h1,
    WSTS_EXEC    = 3'h3,
    WSTS_WAIT    = 3'h2,
    WSTS_RESTORE = 3'h6
  } wsts_state_t;

  typedef struct packed {
    logic [2:0]  width;
    logic        extended;
    logic [11:0] addr;
    logic [3:0]  delay;
    logic [3:0]  lsb;
    logic [7:0]  data;
  } wsts_step_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic [3:0]  lsb;
    logic [2:0]  width;
    logic [7:0]  data;
  } wsts_cfg_write_t;
endpackage

/* logic/wsts_top.sv */
// Write sequencer with trigger selection, status and an Avalon-MM slave.
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "wsts_cfg.svh"

module wsts_top #(
  parameter int SHORT_STEP_CYCLES =
    (`WSTS_SHORT_STEP_NS * `WSTS_CLK_MHZ + 999) / 1000,
  parameter int UNIT_STEP_CYCLES  =
    (`WSTS_UNIT_STEP_NS * `WSTS_CLK_MHZ + 999) / 1000
) (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     sw_reset_req,
  input  wire logic                     sleep_enter,
  input  wire logic                     wake_req,
  input  wire logic [15:0]              avs_address,
  input  wire logic                     avs_read,
  input  wire logic                     avs_write,
  input  wire logic [31:0]              avs_writedata,
  input  wire logic [3:0]               avs_byteenable,
  output logic      [31:0]              avs_readdata,
  output logic                          avs_waitrequest,
  input  wire logic                     first_level_detect,
  input  wire logic [1:0]               mic_clamp_status,
  input  wire logic [1:0]               mic_clamp_jd_control,
  input  wire logic [1:0]               mic_clamp_jd_change,
  input  wire logic                     log_not_empty,
  input  wire logic [7:0]               trim_data,
  output wsts_pkg::wsts_cfg_write_t     cfg_write,
  output logic                          sequencer_running_flag
);
  localparam int NTRIG = 6;
  localparam int CW    = 32;

  wsts_pkg::wsts_state_t state;
  wsts_pkg::wsts_state_t next_state;
  wsts_pkg::wsts_step_t  step;
  logic [31:0] mem [`WSTS_MEM_DEPTH];

  logic [`WSTS_IDX_W-1:0] level_detect_rise_start;
  logic [`WSTS_IDX_W-1:0] level_detect_fall_start;
  logic [`WSTS_IDX_W-1:0] clamp_rise_start;
  logic [`WSTS_IDX_W-1:0] clamp_fall_start;
  logic [`WSTS_IDX_W-1:0] log_nonempty_start;
  logic                   level_detect_seq_enable;
  logic                   clamp_rise_seq_enable;
  logic                   clamp_fall_seq_enable;
  logic [`WSTS_IDX_W-1:0] mem_index;
  logic [`WSTS_IDX_W-1:0] sequencer_position;
  logic [`WSTS_IDX_W-1:0] run_index;
  logic [`WSTS_IDX_W-1:0] restore_index;
  logic [22:0]            base_addr;
  logic [CW-1:0]          wait_count;
  logic [NTRIG-1:0]       pending;
  logic                   restore_req;
  logic                   level_prev;
  logic                   clamp_prev;
  logic                   log_prev;

  // Bus decode: a request is answered one cycle after it is first seen.
  wire        bus_req   = (avs_read | avs_write) & avs_waitrequest;
  wire        bus_wr    = avs_write & ~avs_waitrequest;
  wire [15:0] reg_index = {2'h0, avs_address[15:2]};
  wire        word_ok   = (avs_address[1:0] == 2'h0);
  wire        sel_status  = word_ok & (reg_index == `WSTS_REG_STATUS);
  wire        sel_command = word_ok & (reg_index == `WSTS_REG_COMMAND);
  wire        sel_enable  = word_ok & (reg_index == `WSTS_REG_TRIG_ENABLE);
  wire        sel_mindex  = word_ok & (reg_index == `WSTS_REG_MEM_INDEX);
  wire        sel_mdata   = word_ok & (reg_index == `WSTS_REG_MEM_DATA);
  wire        sel_crise   = word_ok & (reg_index == `WSTS_REG_CLAMP_RISE);
  wire        sel_cfall   = word_ok & (reg_index == `WSTS_REG_CLAMP_FALL);
  wire        sel_lrise   = word_ok & (reg_index == `WSTS_REG_LEVEL_RISE);
  wire        sel_lfall   = word_ok & (reg_index == `WSTS_REG_LEVEL_FALL);
  wire        sel_log     = word_ok & (reg_index == `WSTS_REG_LOG_START);

  // Byte enables merge the write data into the old register contents.
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[i*8 +: 8] = new_v[i*8 +: 8];
    return r;
  endfunction

  function automatic logic [`WSTS_IDX_W-1:0] idx_wr(
    input logic [`WSTS_IDX_W-1:0] old_v);
    logic [31:0] m;
    m = merge({23'h0, old_v}, avs_writedata, avs_byteenable);
    return m[`WSTS_IDX_W-1:0];
  endfunction

  wire [31:0] wr_merged_enable = merge({29'h0, clamp_fall_seq_enable,
                                        clamp_rise_seq_enable,
                                        level_detect_seq_enable},
                                       avs_writedata, avs_byteenable);
  wire        cmd_restore = bus_wr & sel_command & avs_byteenable[0] &
                            avs_writedata[`WSTS_CMD_RESTORE_BIT];
  wire        cmd_boot    = bus_wr & sel_command & avs_byteenable[0] &
                            avs_writedata[`WSTS_CMD_BOOT_BIT];
  wire        mem_wr      = bus_wr & sel_mdata & (state != wsts_pkg::WSTS_RESTORE)
                            & (mem_index <= `WSTS_IDX_LAST);
  wire [31:0] mem_rd      = (mem_index <= `WSTS_IDX_LAST) ?
                            mem[mem_index] : 32'h0;

  wire [31:0] status_word = {22'h0, sequencer_running_flag,
                             sequencer_position};
  wire [31:0] next_readdata =
      sel_status ? status_word :
      sel_enable ? {29'h0, clamp_fall_seq_enable, clamp_rise_seq_enable,
                    level_detect_seq_enable} :
      sel_mindex ? {23'h0, mem_index} :
      sel_mdata  ? mem_rd :
      sel_crise  ? {23'h0, clamp_rise_start} :
      sel_cfall  ? {23'h0, clamp_fall_start} :
      sel_lrise  ? {23'h0, level_detect_rise_start} :
      sel_lfall  ? {23'h0, level_detect_fall_start} :
      sel_log    ? {23'h0, log_nonempty_start} : 32'h0;

  // Trigger sources; the second level controller has no path here.
  wire level_rise = level_detect_seq_enable & first_level_detect &
                    ~level_prev;
  wire level_fall = level_detect_seq_enable & ~first_level_detect &
                    level_prev;
  // The clamp under jack-detect control is the only one observed; clamp 0 if both are.
  wire clamp_sel    = ~mic_clamp_jd_control[0] & mic_clamp_jd_control[1];
  wire clamp_owned  = |mic_clamp_jd_control;
  wire clamp_now    = mic_clamp_status[clamp_sel];
  wire clamp_by_jd  = clamp_owned & mic_clamp_jd_change[clamp_sel];
  wire clamp_rise   = clamp_rise_seq_enable & clamp_by_jd & clamp_now &
                      ~clamp_prev;
  wire clamp_fall   = clamp_fall_seq_enable & clamp_by_jd & ~clamp_now &
                      clamp_prev;
  wire log_rise     = log_not_empty & ~log_prev;
  wire boot_event   = cmd_boot | sw_reset_req | wake_req;

  wire [NTRIG-1:0] trig_set = {log_rise, clamp_fall, clamp_rise,
                               level_fall, level_rise, boot_event};
  // Lowest bit wins: boot, level rise, level fall, clamp rise, clamp fall,
  // then the event log.
  wire [NTRIG-1:0] grant    = pending & (~pending + 6'h01);
  wire             take     = (state == wsts_pkg::WSTS_IDLE) & (|pending);
  wire [NTRIG-1:0] trig_clr = take ? grant : 6'h00;
  wire [NTRIG-1:0] next_pending = (pending & ~trig_clr) | trig_set;
  wire [`WSTS_IDX_W-1:0] grant_start =
      grant[0] ? `WSTS_IDX_BOOT :
      grant[1] ? level_detect_rise_start :
      grant[2] ? level_detect_fall_start :
      grant[3] ? clamp_rise_start :
      grant[4] ? clamp_fall_start :
      log_nonempty_start;
  wire start_run  = take & (grant_start != `WSTS_IDX_ABORT);

  // Step decode and timing of the wait after each write.
  wire ext_base = step.extended &
                  ({step.width, step.extended, step.addr[11:8]} ==
                   `WSTS_EXT_BASE_OP);
  wire ext_jump = step.extended &
                  ({step.width, step.extended, step.addr} ==
                   `WSTS_EXT_JUMP_OP);
  wire [31:0] step_word = {step.width, step.extended, step.addr,
                           step.delay, step.lsb, step.data};
  wire short_step = (step.delay == `WSTS_DELAY_NONE) |
                    (step.delay == `WSTS_DELAY_END);
  wire [CW-1:0] unit_mult = (CW'(1) << step.delay) - CW'(1);
  wire [CW-1:0] step_cycles = short_step ? CW'(SHORT_STEP_CYCLES) :
                              CW'(UNIT_STEP_CYCLES) * unit_mult;
  wire last_step  = (step.delay == `WSTS_DELAY_END);
  wire [`WSTS_IDX_W-1:0] next_index = run_index + 9'h001;
  wire index_out  = (run_index > `WSTS_IDX_LAST);
  wire restore_done = (restore_index == `WSTS_IDX_LAST);
  wire restart_mem  = restore_req | sleep_enter;

  // Default contents: the boot region opens with a single closing step
  // that copies the trim byte into the configuration.
  wire [31:0] boot_word = {`WSTS_TRIM_WIDTH, 1'b0, `WSTS_TRIM_ADDR,
                           `WSTS_DELAY_END, 4'h0, trim_data};
  wire [31:0] default_word = (restore_index == `WSTS_IDX_BOOT) ?
                             boot_word : 32'h0;

  always_comb
  begin
    next_state = state;
    case (state)
      wsts_pkg::WSTS_IDLE:
        if (start_run)
          next_state = wsts_pkg::WSTS_FETCH;
      wsts_pkg::WSTS_FETCH:
        next_state = index_out ? wsts_pkg::WSTS_IDLE : wsts_pkg::WSTS_EXEC;
      wsts_pkg::WSTS_EXEC:
        if (ext_jump | ext_base)
          next_state = wsts_pkg::WSTS_FETCH;
        else
          next_state = wsts_pkg::WSTS_WAIT;
      wsts_pkg::WSTS_WAIT:
        if (wait_count <= CW'(1))
          next_state = last_step ? wsts_pkg::WSTS_IDLE :
                       wsts_pkg::WSTS_FETCH;
      wsts_pkg::WSTS_RESTORE:
        if (restore_done)
          next_state = wsts_pkg::WSTS_IDLE;
      default:
        next_state = wsts_pkg::WSTS_IDLE;
    endcase
    if (restart_mem & (state != wsts_pkg::WSTS_RESTORE))
      next_state = wsts_pkg::WSTS_RESTORE;
  end

  // Bus answer path.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
    end
    else
    begin
      avs_waitrequest <= ~bus_req;
      if (bus_req & avs_read)
        avs_readdata <= next_readdata;
    end
  end

  // Host-written configuration; these survive a software reset.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      level_detect_rise_start <= `WSTS_IDX_RESET;
      level_detect_fall_start <= `WSTS_IDX_RESET;
      clamp_rise_start        <= `WSTS_IDX_RESET;
      clamp_fall_start        <= `WSTS_IDX_RESET;
      log_nonempty_start      <= `WSTS_IDX_RESET;
      level_detect_seq_enable <= 1'b0;
      clamp_rise_seq_enable   <= 1'b0;
      clamp_fall_seq_enable   <= 1'b0;
      mem_index               <= 9'h000;
    end
    else if (bus_wr)
    begin
      if (sel_lrise)
        level_detect_rise_start <= idx_wr(level_detect_rise_start);
      if (sel_lfall)
        level_detect_fall_start <= idx_wr(level_detect_fall_start);
      if (sel_crise)
        clamp_rise_start <= idx_wr(clamp_rise_start);
      if (sel_cfall)
        clamp_fall_start <= idx_wr(clamp_fall_start);
      if (sel_log)
        log_nonempty_start <= idx_wr(log_nonempty_start);
      if (sel_mindex)
        mem_index <= idx_wr(mem_index);
      if (sel_enable)
      begin
        level_detect_seq_enable <= wr_merged_enable[`WSTS_EN_LEVEL_BIT];
        clamp_rise_seq_enable   <= wr_merged_enable[`WSTS_EN_CLAMP_RISE_BIT];
        clamp_fall_seq_enable   <= wr_merged_enable[`WSTS_EN_CLAMP_FALL_BIT];
      end
    end
  end

  // Sequencer memory: restore walk or host write; no reset of its own.
  always_ff @(posedge clk)
  begin
    if (state == wsts_pkg::WSTS_RESTORE)
      mem[restore_index] <= default_word;
    else if (mem_wr)
      mem[mem_index] <= merge(mem_rd, avs_writedata, avs_byteenable);
  end

  // Edge history and pending triggers; a boot is pending out of reset.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      level_prev  <= 1'b0;
      clamp_prev  <= 1'b0;
      log_prev    <= 1'b0;
      pending     <= 6'h01;
      restore_req <= 1'b0;
    end
    else
    begin
      level_prev  <= first_level_detect;
      clamp_prev  <= clamp_now;
      log_prev    <= log_not_empty;
      pending     <= next_pending;
      restore_req <= cmd_restore;
    end
  end

  // Sequencer engine.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state                  <= wsts_pkg::WSTS_RESTORE;
      step                   <= '0;
      run_index              <= 9'h000;
      restore_index          <= 9'h000;
      sequencer_position     <= 9'h000;
      base_addr              <= 23'h0;
      wait_count             <= '0;
      cfg_write              <= '0;
      sequencer_running_flag <= 1'b1;
    end
    else
    begin
      state                  <= next_state;
      sequencer_running_flag <= (next_state != wsts_pkg::WSTS_IDLE);
      cfg_write.valid        <= 1'b0;
      if (state != wsts_pkg::WSTS_RESTORE)
        restore_index <= 9'h000;
      else if (!restore_done)
        restore_index <= restore_index + 9'h001;
      case (state)
        wsts_pkg::WSTS_IDLE:
          if (start_run)
          begin
            run_index <= grant_start;
            base_addr <= 23'h0;
          end
        wsts_pkg::WSTS_FETCH:
          if (!index_out)
          begin
            step               <= mem[run_index];
            sequencer_position <= run_index;
          end
        wsts_pkg::WSTS_EXEC:
          if (ext_jump)
            run_index <= step_word[`WSTS_IDX_W-1:0];
          else if (ext_base)
          begin
            base_addr <= step_word[22:0];
            run_index <= next_index;
          end
          else
          begin
            cfg_write.valid <= 1'b1;
            cfg_write.addr  <= {base_addr, 9'h000} + {20'h0, step.addr};
            cfg_write.lsb   <= step.lsb;
            cfg_write.width <= step.width;
            cfg_write.data  <= step.data;
            wait_count      <= step_cycles;
          end
        wsts_pkg::WSTS_WAIT:
          if (wait_count > CW'(1))
            wait_count <= wait_count - CW'(1);
          else
            run_index <= next_index;
        default:
          run_index <= 9'h000;
      endcase
    end
  end
endmodule

/* sim/wsts_event_src.sv */
// Model of the on-chip event sources that feed the sequencer triggers.
`timescale 1ns/1ps
module wsts_event_src (
  input  wire logic       clk,
  output logic            first_level_detect,
  output logic [1:0]      mic_clamp_status,
  output logic [1:0]      mic_clamp_jd_change,
  output logic            log_not_empty
);
  initial
  begin
    first_level_detect = 1'b0;
    mic_clamp_status = 2'h0;
    mic_clamp_jd_change = 2'h0;
    log_not_empty = 1'b0;
  end

  // Only controller one has a detect line; controller two has no path.
  task ev(input logic lvl, input logic lg);
    @(posedge clk);
    first_level_detect <= lvl;
    log_not_empty <= lg;
  endtask

  // The cause flag is high only in the cycle the clamp status changes.
  task clamp(input logic c, input logic v, input logic jd);
    @(posedge clk);
    mic_clamp_status[c] <= v;
    mic_clamp_jd_change[c] <= jd;
    @(posedge clk);
    mic_clamp_jd_change <= 2'h0;
  endtask
endmodule

/* sim/wsts_chk.sv */
// Port-level assertions for the write sequencer trigger and status block.
`timescale 1ns/1ps
module wsts_chk #(
  parameter int SHORT_STEP_CYCLES = 825,
  parameter int UNIT_STEP_CYCLES  = 15360
) (
  input wire logic                      clk,
  input wire logic                      rst,
  input wire logic                      sw_reset_req,
  input wire logic                      sleep_enter,
  input wire logic                      wake_req,
  input wire logic [15:0]               avs_address,
  input wire logic                      avs_read,
  input wire logic                      avs_write,
  input wire logic [31:0]               avs_readdata,
  input wire logic                      avs_waitrequest,
  input wire logic                      first_level_detect,
  input wire logic [1:0]                mic_clamp_status,
  input wire logic [1:0]                mic_clamp_jd_change,
  input wire logic                      log_not_empty,
  input wire logic [7:0]                trim_data,
  input wire wsts_pkg::wsts_cfg_write_t cfg_write,
  input wire logic                      sequencer_running_flag
);
  logic        lvl_q;
  logic        log_q;
  logic [1:0]  clamp_q;
  logic [13:0] reg_ix;
  logic        zero_read;
  logic        any_event;

  always_ff @(posedge clk)
  begin
    lvl_q <= first_level_detect;
    log_q <= log_not_empty;
    clamp_q <= mic_clamp_status;
  end

  assign reg_ix = avs_address[15:2];
  assign zero_read = avs_address[1:0] != 2'h0 || reg_ix == 14'h0018 ||
    !(reg_ix inside {14'h0017, 14'h0019, 14'h001A, 14'h001B, 14'h0066,
                     14'h0067, 14'h006E, 14'h006F, 14'h0078});
  // Anything that could legally start a run; unqualified clamp moves excluded.
  assign any_event = (first_level_detect != lvl_q) || avs_write ||
    (|((mic_clamp_status ^ clamp_q) & mic_clamp_jd_change)) ||
    (log_not_empty && !log_q) || sw_reset_req || sleep_enter || wake_req;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_status_read;
    avs_read && avs_waitrequest && avs_address == 16'h005C ##1
      !avs_waitrequest && $stable(sequencer_running_flag);
  endsequence
  sequence s_zero_read;
    avs_read && avs_waitrequest && zero_read ##1 !avs_waitrequest;
  endsequence
  sequence s_quiet;
    (!sequencer_running_flag && !any_event) [*4];
  endsequence

  a_quiet_idle: assert property (s_quiet |=> !sequencer_running_flag)
    else $error("sequencer started without a qualified trigger");
  a_status_busy: assert property (
    s_status_read |-> avs_readdata[9] == sequencer_running_flag)
    else $error("status busy bit disagrees with running flag");
  a_read_zero: assert property (s_zero_read |-> avs_readdata == 32'h0)
    else $error("command or unmapped read returned nonzero");
  a_wait_answer: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered in one cycle");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_write_busy: assert property (cfg_write.valid |-> sequencer_running_flag)
    else $error("configuration write while sequencer idle");
  a_boot_flag: assert property ($fell(rst) |-> sequencer_running_flag [*8])
    else $error("sequencer not busy after reset release");
  a_boot_write: assert property ($fell(rst) |-> ##[505:530]
    (cfg_write.valid && cfg_write.addr == 32'h0 &&
     cfg_write.width == 3'h7 && cfg_write.data == trim_data))
    else $error("boot trim write missing after reset");
  a_sleep_busy: assert property (sleep_enter |-> ##[1:3] sequencer_running_flag)
    else $error("memory restore not started on sleep");
endmodule

bind wsts_top wsts_chk #(
  .SHORT_STEP_CYCLES(SHORT_STEP_CYCLES), .UNIT_STEP_CYCLES(UNIT_STEP_CYCLES)
) chk_u (
  .clk(clk), .rst(rst), .sw_reset_req(sw_reset_req),
  .sleep_enter(sleep_enter), .wake_req(wake_req), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .first_level_detect(first_level_detect),
  .mic_clamp_status(mic_clamp_status), .log_not_empty(log_not_empty),
  .mic_clamp_jd_change(mic_clamp_jd_change), .trim_data(trim_data),
  .cfg_write(cfg_write), .sequencer_running_flag(sequencer_running_flag)
);

/* sim/wsts_tb_top.sv */
// Self-checking bench for the write sequencer trigger and status block.
`timescale 1ns/1ps
module wsts_tb_top;
  logic                      clk, rst, avs_read, avs_write, avs_waitrequest;
  logic                      running, first_level_detect, log_not_empty;
  logic [2:0]                ctl;
  logic [15:0]               avs_address;
  logic [31:0]               avs_writedata, avs_readdata, rd, wa, wb, wc;
  logic [3:0]                avs_byteenable;
  logic [1:0]                mic_clamp_status, jd_control, jd_change;
  logic [7:0]                trim;
  logic [7:0]                regs [5];
  logic [47:0]               boot;
  logic [47:0]               exp_q [$];
  wsts_pkg::wsts_cfg_write_t cfg_write;
  int                        err_count, compares, cyc;

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  wsts_top #(.SHORT_STEP_CYCLES(4), .UNIT_STEP_CYCLES(8)) dut_u (
    .clk(clk), .rst(rst), .sw_reset_req(ctl[0]), .sleep_enter(ctl[1]),
    .wake_req(ctl[2]), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .first_level_detect(first_level_detect),
    .mic_clamp_status(mic_clamp_status), .mic_clamp_jd_control(jd_control),
    .mic_clamp_jd_change(jd_change), .log_not_empty(log_not_empty),
    .trim_data(trim), .cfg_write(cfg_write), .sequencer_running_flag(running));

  wsts_event_src src_u (
    .clk(clk), .first_level_detect(first_level_detect),
    .mic_clamp_status(mic_clamp_status), .mic_clamp_jd_change(jd_change),
    .log_not_empty(log_not_empty));

  task give_verdict;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge clk);
    avs_address <= {6'h00, idx, 2'h0};
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= wd;
    do
    begin
      @(posedge clk);
    end
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    check({16'h0, rd}, {16'h0, exp});
  endtask

  task prog(input logic [8:0] i, input logic [31:0] w);
    bus(1'b1, 8'h1A, {23'h0, i});
    bus(1'b1, 8'h1B, w);
  endtask

  // A pending trigger may start one idle cycle after a run ends, so the
  // flag must stay low for eight samples before the sequencer is settled.
  task wait_idle;
    int q;
    q = 0;
    while (q < 8)
    begin
      @(posedge clk);
      q = (running === 1'b0) ? q + 1 : 0;
    end
  endtask

  task trig(input logic lvl, input logic lg);
    src_u.ev(lvl, lg);
    wait_idle;
  endtask

  task ctrig(input logic c, input logic v, input logic jd);
    src_u.clamp(c, v, jd);
    wait_idle;
  endtask

  task pulse(input logic [2:0] v);
    @(posedge clk);
    ctl <= v;
    @(posedge clk);
    ctl <= 3'h0;
  endtask

  function logic [47:0] step(input logic [31:0] w);
    return {1'b1, 20'h0, w[27:16], w[11:8], w[31:29], w[7:0]};
  endfunction

  function logic [31:0] mk(input logic [3:0] d);
    logic [31:0] r;
    r = $urandom;
    return {r[31:29], 1'b0, r[27:16], d, r[11:0]};
  endfunction

  // Every executed step is compared with the model queue in order.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      err_count++;
      give_verdict;
    end
    if (!rst && cfg_write.valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        check(cfg_write, 48'h0);
      else
        check(cfg_write, exp_q.pop_front());
    end
  end

  initial
  begin
    void'($urandom(32'h7A27));
    rst = 1'b1;
    ctl = 3'h0;
    avs_address = 16'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    jd_control = 2'h1;
    trim = 8'($urandom);
    boot = {1'b1, 32'h0, 4'h0, 3'h7, trim};
    regs = '{8'h66, 8'h67, 8'h6E, 8'h6F, 8'h78};
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    exp_q.push_back(boot);
    repeat (520) @(posedge clk);
    wait_idle;
    for (int i = 0; i < 5; i++)
      rd_chk(regs[i], 32'h1FF);
    rd_chk(8'h17, 32'h180);
    rd_chk(8'h7F, 32'h0);
    rd_chk(8'h18, 32'h0);
    wa = mk(4'hF);
    wb = mk(4'h0);
    wc = mk(4'hF);
    prog(9'h00A, wa);
    prog(9'h014, wb);
    prog(9'h015, wc);
    bus(1'b1, 8'h6E, 32'hA);
    bus(1'b1, 8'h6F, 32'h14);
    bus(1'b1, 8'h19, 32'h1);
    exp_q.push_back(step(wa));
    trig(1'b1, 1'b0);
    rd_chk(8'h17, 32'hA);
    exp_q.push_back(step(wb));
    exp_q.push_back(step(wc));
    trig(1'b0, 1'b0);
    rd_chk(8'h17, 32'h15);
    bus(1'b1, 8'h6F, 32'h1FF);
    exp_q.push_back(step(wa));
    trig(1'b1, 1'b0);
    trig(1'b0, 1'b0);
    rd_chk(8'h17, 32'hA);
    bus(1'b1, 8'h19, 32'h0);
    trig(1'b1, 1'b0);
    trig(1'b0, 1'b0);
    bus(1'b1, 8'h66, 32'h14);
    bus(1'b1, 8'h67, 32'hA);
    bus(1'b1, 8'h19, 32'h6);
    for (int i = 0; i < 4; i++)
      ctrig(i[1], ~i[0], i[1]);
    exp_q.push_back(step(wb));
    exp_q.push_back(step(wc));
    ctrig(1'b0, 1'b1, 1'b1);
    exp_q.push_back(step(wa));
    ctrig(1'b0, 1'b0, 1'b1);
    bus(1'b1, 8'h78, 32'hA);
    bus(1'b1, 8'h6E, 32'h14);
    bus(1'b1, 8'h19, 32'h1);
    exp_q.push_back(step(wb));
    exp_q.push_back(step(wc));
    exp_q.push_back(step(wa));
    trig(1'b1, 1'b1);
    rd_chk(8'h17, 32'hA);
    trig(1'b0, 1'b0);
    exp_q.push_back(boot);
    bus(1'b1, 8'h18, 32'h2);
    wait_idle;
    rd_chk(8'h17, 32'h180);
    exp_q.push_back(boot);
    pulse(3'h1);
    wait_idle;
    bus(1'b1, 8'h1A, 32'hA);
    rd_chk(8'h1B, wa);
    pulse(3'h2);
    wait_idle;
    bus(1'b1, 8'h1A, 32'hA);
    rd_chk(8'h1B, 32'h0);
    exp_q.push_back(boot);
    pulse(3'h4);
    wait_idle;
    prog(9'h00A, wa);
    bus(1'b1, 8'h18, 32'h1);
    wait_idle;
    bus(1'b1, 8'h1A, 32'hA);
    rd_chk(8'h1B, 32'h0);
    check(48'(exp_q.size()), 48'h0);
    give_verdict;
  end
endmodule
